// ### rtl/cpu_config.sv
// Processor configuration register, reset mode capture and clock enables.
// Assumes interrupt pins are synchronous to MCLK_I and that board logic
// drives mode vectors on them from reset until the third clock after RSTN_I rises.
//
// How it works
// - Floating unit interrupt replaces one external input when select is 0 to 5; that pin is ignored.
// - Six mode vectors are taken from the interrupt inputs on the third clock after RSTN_I rises.
// - Register is 32 bits: lock, slow, refill, select, halt, rf, split.
// - After lock is written one, later writes are ignored.
// - Slow turnaround adds time when memory hands the bus back.
// - Refill field picks four words or one; no flush needed.
// - Three-bit select names which interrupt input carries the float interrupt; values 6 and 7 name none.
// - Halt stalls the core until an interrupt or reset.
// - Reduced frequency divides the execution clock by sixteen.
// - Split one gives 8k/8k; zero gives 16k instruction, 4k data.
// - Reserved bits written zero and always read as zero.
// - Reset sets select to 3, clears lock/split/halt/rf; others from vectors.
// - Register is coprocessor register 3, reached only by move instructions.
// - Unit clock plus half bus: core at input rate, bus at half.
// - Half bus mode runs the bus at half the core rate.
// - Reduced frequency also slows the bus enable.
`timescale 1ns/100ps
`default_nettype none

module cpu_config (
    input  wire logic                 MCLK_I,
    input  wire logic                 RSTN_I,
    input  wire logic [5:0]           IRQ_I,
    input  wire logic                 FPU_IRQ_I,
    input  wire cfg_pkg::cp_req_s     CP_REQ_I,
    output logic [31:0]               CP_RDATA_O,
    output logic                      CP_ACK_O,
    output logic [5:0]                IRQ_O,
    output cfg_pkg::mode_s            MODES_O,
    output cfg_pkg::cache_bus_s       CACHE_BUS_O,
    output logic                      CORE_EN_O,
    output logic                      BUS_EN_O,
    output logic                      HALTED_O
);
    import cfg_pkg::*;

    typedef struct packed {
        logic       sampled;
        logic       lock;
        logic       slow;
        logic       refill;
        logic [2:0] fpi;
        logic       halt;
        logic       rf;
        logic       ac;
        mode_s      modes;
        logic [5:0] div_cnt;
        logic       bus_phase;
        logic       core_en;
        logic       bus_en;
        logic [5:0] irq;
        logic [31:0] rdata;
        logic       ack;
        cache_bus_s cache_bus;
    } state_s;

    state_s     state;
    state_s     next_state;
    logic [1:0] rst_sync;
    logic       rst_n;

    // Period of the execution tick in input clocks
    function automatic logic [5:0] tick_period(input logic unit_rate, input logic reduced);
        logic [5:0] base;
        base = unit_rate ? 6'h01 : HALF_INPUT_DIV;
        tick_period = reduced ? 6'((base * RF_DIVIDE)) : base;
    endfunction

    // register field layout
    // Image of the register as software reads it
    function automatic logic [31:0] cfg_image(input state_s s);
        logic [31:0] img;
        img = RESERVED_READ;
        img[LOCK_BIT]        = s.lock;
        img[SLOW_BIT]        = s.slow;
        img[REFILL_BIT]      = s.refill;
        img[FPI_MSB:FPI_LSB] = s.fpi;
        img[HALT_BIT]        = s.halt;
        img[RF_BIT]          = s.rf;
        img[AC_BIT]          = s.ac;
        cfg_image = img;
    endfunction

    // ========================================================
    // Reset release
    // ========================================================
    // Two stages so release never lands near a clock edge
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ========================================================
    // Next state
    // ========================================================
    always_comb begin
        logic       cfg_hit;
        logic       tick;
        logic       any_irq;
        logic [5:0] period;
        next_state = state;
        cfg_hit    = (CP_REQ_I.regnum == CFG_REG_NUM);
        period     = tick_period(state.modes.unit_rate_clock_enable, state.rf);
        tick       = (state.div_cnt >= period - 6'h01);
        any_irq    = |state.irq;

        if (!state.sampled) begin
            next_state.sampled                        = 1'b1;
            next_state.modes.coherent_dma_enable      = ~IRQ_I[5];
            next_state.modes.unit_rate_clock_enable   = ~IRQ_I[4];
            next_state.modes.half_bus_enable          = ~IRQ_I[3];
            next_state.modes.data_block_refill_select = ~IRQ_I[2];
            next_state.modes.tristate_test            = ~IRQ_I[1];
            next_state.modes.high_byte_first_order    = ~IRQ_I[0];
            next_state.refill = ~IRQ_I[2];
            next_state.slow   = ~IRQ_I[3];
            next_state.irq    = 6'h00;
        end else begin
            for (int i = 0; i < IRQ_COUNT; i++) begin
                next_state.irq[i] = (state.fpi == 3'(i)) ? FPU_IRQ_I : IRQ_I[i];
            end
        end

        if (any_irq) begin
            next_state.halt = 1'b0;
        end

        next_state.ack = state.sampled && (CP_REQ_I.wr || CP_REQ_I.rd);
        if (state.sampled && CP_REQ_I.wr && cfg_hit && !state.lock) begin
            next_state.lock   = CP_REQ_I.wdata[LOCK_BIT];
            next_state.slow   = CP_REQ_I.wdata[SLOW_BIT];
            next_state.refill = CP_REQ_I.wdata[REFILL_BIT];
            next_state.fpi    = CP_REQ_I.wdata[FPI_MSB:FPI_LSB];
            next_state.halt   = CP_REQ_I.wdata[HALT_BIT];  // Set beats a same-cycle wake
            next_state.rf     = CP_REQ_I.wdata[RF_BIT];
            next_state.ac     = CP_REQ_I.wdata[AC_BIT];
        end
        if (state.sampled && CP_REQ_I.rd) begin
            next_state.rdata = cfg_hit ? cfg_image(state) : 32'h0000_0000;
        end

        next_state.div_cnt = tick ? 6'h00 : state.div_cnt + 6'h01;
        next_state.core_en = state.sampled && tick && !state.halt;
        if (state.sampled && tick) begin
            next_state.bus_phase = ~state.bus_phase;
            next_state.bus_en    = state.modes.half_bus_enable ? state.bus_phase : 1'b1;
        end else begin
            next_state.bus_en = 1'b0;
        end

        next_state.cache_bus.slow_turnaround       = state.slow;
        next_state.cache_bus.refill_words          = state.refill ? REFILL_BLOCK : REFILL_SINGLE;
        next_state.cache_bus.alternate_cache_split = state.ac;
        next_state.cache_bus.icache_kb             = state.ac ? CACHE_KB_ALT : ICACHE_KB_BASE;
        next_state.cache_bus.dcache_kb             = state.ac ? CACHE_KB_ALT : DCACHE_KB_BASE;
    end

    // ========================================================
    // State register
    // ========================================================
    // reset values
    always_ff @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state                           <= '0;
            state.fpi                       <= FPI_RESET;
            state.cache_bus.refill_words    <= REFILL_SINGLE;
            state.cache_bus.icache_kb       <= ICACHE_KB_BASE;
            state.cache_bus.dcache_kb       <= DCACHE_KB_BASE;
        end else begin
            state <= next_state;
        end
    end

    // Every output straight from the state register
    assign CP_RDATA_O  = state.rdata;
    assign CP_ACK_O    = state.ack;
    assign IRQ_O       = state.irq;
    assign MODES_O     = state.modes;
    assign CACHE_BUS_O = state.cache_bus;
    assign CORE_EN_O   = state.core_en;
    assign BUS_EN_O    = state.bus_en;
    assign HALTED_O    = state.halt;

endmodule

`default_nettype wire

// ### rtl/cfg_pkg.sv
// Constants and carrier types for the processor configuration block.
// Assumes one 100 MHz clock and a coprocessor move port from the core.
package cfg_pkg;

    // ========================================================
    // Register addressing and layout
    // ========================================================
    localparam logic [4:0]  CFG_REG_NUM     = 5'h03;  // system coprocessor register number
    localparam int          LOCK_BIT        = 31;
    localparam int          SLOW_BIT        = 30;
    localparam int          REFILL_BIT      = 29;
    localparam int          FPI_MSB         = 28;
    localparam int          FPI_LSB         = 26;
    localparam int          HALT_BIT        = 25;
    localparam int          RF_BIT          = 24;
    localparam int          AC_BIT          = 23;
    localparam int          IRQ_COUNT       = 6;

    // ========================================================
    // Reset values
    // ========================================================
    localparam logic [2:0]  FPI_RESET       = 3'h3;   // Floating interrupt on input 3
    localparam logic [31:0] RESERVED_READ   = 32'h0000_0000;

    // ========================================================
    // Clock rates and cache figures
    // ========================================================
    localparam logic [5:0]  RF_DIVIDE       = 6'h10;  // Reduced frequency divide by 16
    localparam logic [5:0]  HALF_INPUT_DIV  = 6'h02;  // Double-rate input: core at half
    localparam logic [2:0]  REFILL_BLOCK    = 3'h4;
    localparam logic [2:0]  REFILL_SINGLE   = 3'h1;
    localparam logic [4:0]  ICACHE_KB_BASE  = 5'h10;
    localparam logic [4:0]  DCACHE_KB_BASE  = 5'h04;
    localparam logic [4:0]  CACHE_KB_ALT    = 5'h08;

    // ========================================================
    // Carriers
    // ========================================================
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  regnum;
        logic [31:0] wdata;
    } cp_req_s;

    typedef struct packed {
        logic coherent_dma_enable;
        logic unit_rate_clock_enable;
        logic half_bus_enable;
        logic data_block_refill_select;
        logic tristate_test;
        logic high_byte_first_order;
    } mode_s;

    typedef struct packed {
        logic       slow_turnaround;
        logic [2:0] refill_words;
        logic [4:0] icache_kb;
        logic [4:0] dcache_kb;
        logic       alternate_cache_split;
    } cache_bus_s;

endpackage

// ### dv/cpu_config_props.sv
// Port assertions for cpu_config.
// Bound to the design top from the bench top file.
`timescale 1ns/100ps
`default_nettype none
module cpu_config_props (
    input wire logic                MCLK_I,
    input wire logic                RSTN_I,
    input wire logic [5:0]          IRQ_I,
    input wire logic                FPU_IRQ_I,
    input wire cfg_pkg::cp_req_s    CP_REQ_I,
    input wire logic [31:0]         CP_RDATA_O,
    input wire logic                CP_ACK_O,
    input wire logic [5:0]          IRQ_O,
    input wire cfg_pkg::mode_s      MODES_O,
    input wire cfg_pkg::cache_bus_s CACHE_BUS_O,
    input wire logic                CORE_EN_O,
    input wire logic                BUS_EN_O,
    input wire logic                HALTED_O
);
    import cfg_pkg::*;
    // ========================================
    // Helpers: edges since release, lock copy
    logic [1:0] up;
    logic       lk;
    logic       wr_ok;
    logic       rd_ok;
    assign wr_ok = up == 2'h3 && CP_REQ_I.wr && CP_REQ_I.regnum == CFG_REG_NUM && !lk;
    assign rd_ok = up == 2'h3 && CP_REQ_I.rd;
    // Requests before the capture edge are not taken, so count three edges
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            up <= 2'h0;
            lk <= 1'b0;
        end else begin
            if (up != 2'h3) up <= up + 2'h1;
            if (wr_ok) lk <= CP_REQ_I.wdata[LOCK_BIT];
        end
    end
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);
    a_ack_next: assert property (up == 2'h3 |=> CP_ACK_O == $past(CP_REQ_I.wr | CP_REQ_I.rd))
        else $error("ack mistimed");
    a_read_reserved: assert property (rd_ok && CP_REQ_I.regnum == CFG_REG_NUM
        |=> CP_RDATA_O[22:0] == 23'h0 && CP_RDATA_O[LOCK_BIT] == $past(lk)) else $error("bad read");
    a_unmapped_zero: assert property (rd_ok && CP_REQ_I.regnum != CFG_REG_NUM
        |=> CP_RDATA_O == 32'h0) else $error("unmapped read not zero");
    a_modes_held: assert property ($past(up) == 2'h3 |-> $stable(MODES_O))
        else $error("modes moved");
    a_halt_write: assert property (wr_ok |=> HALTED_O == $past(CP_REQ_I.wdata[HALT_BIT]))
        else $error("halt not written");
    a_halt_wake: assert property (HALTED_O && IRQ_O != 6'h00 && !wr_ok |=> !HALTED_O)
        else $error("halt not woken");
    a_core_stall: assert property (HALTED_O && $past(HALTED_O) |-> !CORE_EN_O)
        else $error("core runs while halted");
    a_split_sizes: assert property (CACHE_BUS_O.alternate_cache_split ?
        (CACHE_BUS_O.icache_kb == CACHE_KB_ALT && CACHE_BUS_O.dcache_kb == CACHE_KB_ALT) :
        (CACHE_BUS_O.icache_kb == ICACHE_KB_BASE && CACHE_BUS_O.dcache_kb == DCACHE_KB_BASE))
        else $error("cache split sizes");
    c_halt_wake: cover property (HALTED_O ##1 !HALTED_O);
    c_lock_write: cover property (lk && CP_REQ_I.wr);
    c_alt_split: cover property (CACHE_BUS_O.alternate_cache_split);
endmodule
`default_nettype wire

// ### dv/board_mode_drive.sv
// Board model: mode vectors on the interrupt pins around reset.
// Assumes the bench sets the vector and the run-time levels.
`timescale 1ns/100ps
`default_nettype none
module board_mode_drive (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic [5:0] vec_i,
    input  wire logic [5:0] irq_i,
    output logic      [5:0] pins_o
);
    logic [2:0] hold;
    // Vector held past release so the capture edge still sees it
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) hold <= 3'h0;
        else if (hold != 3'h3) hold <= hold + 3'h1;
    end
    // vectors only around reset; gone before the first routed cycle
    assign pins_o = (hold == 3'h3) ? irq_i : vec_i;
endmodule
`default_nettype wire

// ### dv/cpu_config_bench.sv
// Self-checking bench for cpu_config with a board model on the pins.
// Assumes a 100 MHz clock and the constants of cfg_pkg.
`timescale 1ns/100ps
`default_nettype none
module cpu_config_bench;
    import cfg_pkg::*;
    logic        mclk, rstn, fpu, ack, core_en, bus_en, halted;
    logic [5:0]  vec, irq_drv, pins, irq_o;
    logic [31:0] rdata, seed, d, n_fail, checks;
    logic [32:0] e;
    logic [32:0] exp_q[$];
    cp_req_s     req;
    mode_s       modes;
    cache_bus_s  cb;
    int          tick;
    board_mode_drive i_board_mode_drive (.clk_i(mclk), .rstn_i(rstn), .vec_i(vec),
        .irq_i(irq_drv), .pins_o(pins));
    cpu_config i_cpu_config (.MCLK_I(mclk), .RSTN_I(rstn), .IRQ_I(pins), .FPU_IRQ_I(fpu),
        .CP_REQ_I(req), .CP_RDATA_O(rdata), .CP_ACK_O(ack), .IRQ_O(irq_o), .MODES_O(modes),
        .CACHE_BUS_O(cb), .CORE_EN_O(core_en), .BUS_EN_O(bus_en), .HALTED_O(halted));
    // ========================================
    // Clock, helpers and checking
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        checks++;
        if (g !== ex) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, ex, g);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // One coprocessor move; the note is queued for the watcher
    task automatic cp(input logic w, input logic [4:0] rn, input logic [31:0] wd,
                      input logic [31:0] ex);
        @(posedge mclk);
        #1 req = '{w, !w, rn, wd};
        exp_q.push_back({!w, ex});
        @(posedge mclk);
        #1 req = '0;
    endtask
    // Window is a multiple of every period, so the count is phase free
    task automatic rate(input int n, input logic [31:0] ec, input logic [31:0] eb);
        logic [31:0] nc, nb;
        nc = 0;
        nb = 0;
        repeat (n) begin
            @(negedge mclk);
            nc += core_en;
            nb += bus_en;
        end
        chk("core enables", ec, nc);
        chk("bus enables", eb, nb);
    endtask
    task automatic do_reset(input logic [5:0] v);
        @(posedge mclk);
        #1 rstn = 1'b0;
        vec = v;
        exp_q.delete();
        repeat (16) @(posedge mclk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge mclk);
        // Step off the capture edge so the modes have settled
        #1;
    endtask
    // Oldest note answers each acknowledge
    always @(negedge mclk) begin
        if (ack === 1'b1) begin
            chk("pending", 32'h1, {31'h0, exp_q.size() != 0});
            e = exp_q.pop_front();
            if (e[32]) chk("read data", e[31:0], rdata);
        end
    end
    // ========================================
    // Main sequence
    initial begin
        {rstn, fpu, irq_drv, req, n_fail, checks} = '0;
        vec = 6'h3F;
        seed = 32'h0001_6FFB;
        // Random vector, then unit-rate core with half-rate bus
        for (int k = 0; k < 2; k++) begin
            seed = lfsr(seed);
            d = (k == 0) ? seed : 32'h0000_0027;
            do_reset(d[5:0]);
            chk("modes", {26'h0, ~d[5:0]}, {26'h0, modes});
            cp(1'b0, CFG_REG_NUM, 32'h0, {1'b0, ~d[3], ~d[2], FPI_RESET, 26'h0});
            tick = d[4] ? 2 : 1;
            rate(64, 64 / tick, 64 / (tick * (d[3] ? 1 : 2)));
            $display("reset pass %0d done", k);
        end
        repeat (4) begin
            seed = lfsr(seed);
            // software writes reserved bits as zero
            // split may change here; flushing is software's, no cache model here
            d = seed & 32'h7D80_0000;
            cp(1'b1, CFG_REG_NUM, d, 32'h0);
            cp(1'b0, CFG_REG_NUM, 32'h0, d & 32'h7D80_0000);
            chk("cache", {d[30], (d[29] ? 3'h4 : 3'h1), d[23]}, {cb[14:11], cb[0]});
        end
        cp(1'b1, CFG_REG_NUM, 32'h0D00_0000, 32'h0);
        rate(128, 8, 4);
        cp(1'b1, CFG_REG_NUM, 32'h1400_0000, 32'h0);
        irq_drv = 6'h3F;
        repeat (2) @(negedge mclk);
        chk("routed irq", 32'h1F, {26'h0, irq_o});
        @(posedge mclk);
        #1 {irq_drv, fpu} = 7'h01;
        repeat (2) @(negedge mclk);
        chk("routed irq", 32'h20, {26'h0, irq_o});
        @(posedge mclk);
        #1 fpu = 1'b0;
        cp(1'b0, 5'h05, 32'h0, 32'h0);
        cp(1'b1, 5'h02, 32'hFFFF_FFFF, 32'h0);
        cp(1'b0, CFG_REG_NUM, 32'h0, 32'h1400_0000);
        $display("routing test done");
        cp(1'b1, CFG_REG_NUM, 32'h0E00_0000, 32'h0);
        chk("halted", 32'h1, {31'h0, halted});
        // Last pre-halt core tick is still out for one cycle
        @(posedge mclk);
        rate(32, 0, 16);
        @(posedge mclk);
        #1 irq_drv = 6'h01;
        repeat (3) @(negedge mclk);
        chk("halted", 32'h0, {31'h0, halted});
        @(posedge mclk);
        #1 irq_drv = 6'h00;
        cp(1'b1, CFG_REG_NUM, 32'hCC00_0000, 32'h0);
        cp(1'b1, CFG_REG_NUM, 32'h0000_0000, 32'h0);
        cp(1'b0, CFG_REG_NUM, 32'h0, 32'hCC00_0000);
        repeat (2) @(negedge mclk);
        chk("unanswered", 32'h0, exp_q.size());
        $display("halt and lock tests done");
        conclude();
    end
    // Run needs a few microseconds; this cuts a hang short
    initial begin
        #100000;
        n_fail++;
        conclude();
    end
endmodule
bind cpu_config cpu_config_props i_cpu_config_props (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I),
    .IRQ_I(IRQ_I), .FPU_IRQ_I(FPU_IRQ_I), .CP_REQ_I(CP_REQ_I), .CP_RDATA_O(CP_RDATA_O),
    .CP_ACK_O(CP_ACK_O), .IRQ_O(IRQ_O), .MODES_O(MODES_O), .CACHE_BUS_O(CACHE_BUS_O),
    .CORE_EN_O(CORE_EN_O), .BUS_EN_O(BUS_EN_O), .HALTED_O(HALTED_O));
`default_nettype wire
